// ---- mswl_defs.vh ----
`ifndef MSWL_DEFS_VH
`define MSWL_DEFS_VH

////////////////////////////////////////////////////////////////////////
// clock rate and times in their own units
`define MSWL_CLK_MHZ 125
`define MSWL_STBY_US 600
`define MSWL_HDR_LOW_US 5
`define MSWL_TE_MIN_US 10
`define MSWL_TE_MAX_US 100
`define MSWL_WC_SHORT_MS 5
`define MSWL_WC_LONG_MS 10

////////////////////////////////////////////////////////////////////////
// derived cycle counts (least times round up, longest down; all exact here)
`define MSWL_STBY_CYC (`MSWL_STBY_US * `MSWL_CLK_MHZ)
`define MSWL_HDR_LOW_CYC (`MSWL_HDR_LOW_US * `MSWL_CLK_MHZ)
`define MSWL_TE_MIN_CYC (`MSWL_TE_MIN_US * `MSWL_CLK_MHZ)
`define MSWL_TE_MAX_CYC (`MSWL_TE_MAX_US * `MSWL_CLK_MHZ)
`define MSWL_WC_SHORT_CYC (`MSWL_WC_SHORT_MS * 1000 * `MSWL_CLK_MHZ)
`define MSWL_WC_LONG_CYC (`MSWL_WC_LONG_MS * 1000 * `MSWL_CLK_MHZ)

////////////////////////////////////////////////////////////////////////
// header byte, address family, argument byte count and command codes
`define MSWL_HDR_BYTE 8'h55
`define MSWL_FAMILY 4'ha
`define MSWL_ARG_BYTES 2'h2
`define MSWL_OP_READ 8'h03
`define MSWL_OP_CURRENT_ADDRESS_READ_CMD 8'h06
`define MSWL_OP_WRITE 8'h6c
`define MSWL_OP_WREN 8'h96
`define MSWL_OP_WRDI 8'h91
`define MSWL_OP_RDSR 8'h05
`define MSWL_OP_STATUS_WRITE_CMD 8'h6e
`define MSWL_OP_CLR 8'h6d
`define MSWL_OP_SET 8'h67

`endif

// ---- mswl_skid_buf.v ----
`timescale 1ns/1ps
module mswl_skid_buf #(
  parameter W = 8,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];

  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ---- mswl_link.v ----
`timescale 1ns/1ps
`include "mswl_defs.vh"
module mswl_link #(
  parameter [3:0] DEV_CODE = 4'h0,
  parameter [16:0] STBY_CYC = `MSWL_STBY_CYC,
  parameter [20:0] WC_SHORT_CYC = `MSWL_WC_SHORT_CYC,
  parameter [20:0] WC_LONG_CYC = `MSWL_WC_LONG_CYC
) (
  input wire CLK,
  input wire RESET,
  input wire SIO_IN,
  output wire SIO_OUT,
  output wire SIO_OE_N,
  output wire [7:0] RX_DATA,
  output wire RX_VALID,
  input wire RX_READY,
  input wire [7:0] TX_DATA,
  input wire TX_VALID,
  output wire TX_READY,
  output wire WC_START,
  output wire WC_BULK,
  output wire WRITE_BUSY
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_STBY = 7'h02;
  localparam [6:0] ST_HLOW = 7'h04;
  localparam [6:0] ST_HMEAS = 7'h08;
  localparam [6:0] ST_RXB = 7'h10;
  localparam [6:0] ST_SACK = 7'h20;
  localparam [6:0] ST_TX = 7'h40;
  localparam [2:0] PH_HDR = 3'h0;
  localparam [2:0] PH_ADR = 3'h1;
  localparam [2:0] PH_CMD = 3'h2;
  localparam [2:0] PH_ARG = 3'h3;
  localparam [2:0] PH_DAT = 3'h4;
  localparam [2:0] PH_TXD = 3'h5;
  localparam [1:0] WC_NONE = 2'h0;
  localparam [1:0] WC_SHORT = 2'h1;
  localparam [1:0] WC_LONG = 2'h2;
  localparam [15:0] HDR_LOW_CYC = `MSWL_HDR_LOW_CYC;
  localparam [15:0] TE_MIN_CYC = `MSWL_TE_MIN_CYC;
  localparam [15:0] TE_MAX_CYC = `MSWL_TE_MAX_CYC;

  ////////////////////////////////////////////////////////////////////
  // line synchroniser and edge finder
  reg sync1_q;
  reg sync2_q;
  reg prev_q;
  always @(posedge CLK) begin
    // idle level of the pulled-up line, so leaving reset shows no false rise
    if (RESET) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= SIO_IN;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  wire edge_any = sync2_q ^ prev_q;
  wire rise = sync2_q & ~prev_q;
  wire fall = ~sync2_q & prev_q;

  ////////////////////////////////////////////////////////////////////
  // standby pulse detector
  reg armed_q;
  reg [16:0] hcnt_q;
  always @(posedge CLK) begin
    if (RESET) begin
      armed_q <= 1'b0;
      hcnt_q <= 17'h0;
    end else begin
      if (rise) begin
        armed_q <= 1'b1;
      end
      if (~sync2_q | ~armed_q) begin
        hcnt_q <= 17'h0;
      end else if (hcnt_q != STBY_CYC) begin
        hcnt_q <= hcnt_q + 17'h1;
      end
    end
  end
  // fires once per high stretch, so a parked high line does not re-trigger
  wire stby_hit = armed_q & sync2_q & (hcnt_q == STBY_CYC - 17'h1);

  ////////////////////////////////////////////////////////////////////
  // bit timing and protocol state
  reg [6:0] state_q;
  reg [15:0] tcnt_q;
  reg [15:0] period_q;
  reg [2:0] sub_q;
  reg [2:0] ecnt_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg ph_q;
  reg [2:0] phase_q;
  reg [7:0] cmd_q;
  reg [1:0] nargs_q;
  reg sak_q;
  reg [6:0] go_q;
  reg oe_q;
  reg out_q;
  reg [7:0] txb_q;
  reg push_q;
  reg [7:0] pushd_q;
  reg [20:0] wc_q;
  reg wcs_q;
  reg wcb_q;
  wire buf_rdy;

  // a quarter period either side of the expected mid edge
  wire [15:0] half = {1'b0, period_q[15:1]};
  wire [15:0] quarter = {2'b00, period_q[15:2]};
  wire [15:0] lo = period_q - quarter;
  wire [15:0] hi = period_q + quarter;
  wire missed = tcnt_q > hi;
  wire in_win = edge_any & (tcnt_q >= lo) & ~missed;
  wire ack_take = (state_q == ST_RXB) & in_win & (bit_q == 4'd8);
  wire busy = (wc_q != 21'h0);

  ////////////////////////////////////////////////////////////////////
  // acknowledge decision, taken on the master ack mid edge
  wire ack = rise;
  wire c_rd = (cmd_q == `MSWL_OP_READ);
  wire c_wr = (cmd_q == `MSWL_OP_WRITE);
  wire c_ws = (cmd_q == `MSWL_OP_STATUS_WRITE_CMD);
  wire n_rd = (sh_q == `MSWL_OP_READ);
  wire n_wr = (sh_q == `MSWL_OP_WRITE);
  wire n_ws = (sh_q == `MSWL_OP_STATUS_WRITE_CMD);
  wire n_cr = (sh_q == `MSWL_OP_CURRENT_ADDRESS_READ_CMD);
  wire n_sr = (sh_q == `MSWL_OP_RDSR);
  wire n_wl = (sh_q == `MSWL_OP_WREN) | (sh_q == `MSWL_OP_WRDI);
  wire n_bulk = (sh_q == `MSWL_OP_CLR) | (sh_q == `MSWL_OP_SET);
  wire n_blocked = n_rd | n_cr | n_wr | n_ws | n_bulk;
  wire cmd_ok = (n_rd | n_cr | n_wr | n_ws | n_sr | n_wl | n_bulk) & ~(busy & n_blocked);

  reg d_sak;
  reg [6:0] d_go;
  reg [2:0] d_phase;
  reg [1:0] d_nargs;
  reg d_push;
  reg [1:0] d_wc;
  always @* begin
    d_sak = 1'b0;
    d_go = ST_IDLE;
    d_phase = phase_q;
    d_nargs = nargs_q;
    d_push = 1'b0;
    d_wc = WC_NONE;
    case (phase_q)
      PH_HDR: begin
        if (ack) begin
          d_go = ST_RXB;
          d_phase = PH_ADR;
        end
      end
      PH_ADR: begin
        if (sh_q == {`MSWL_FAMILY, DEV_CODE}) begin
          d_sak = 1'b1;
          d_go = ack ? ST_RXB : ST_STBY;
          d_phase = PH_CMD;
        end
      end
      PH_CMD: begin
        if (cmd_ok) begin
          d_push = 1'b1;
          d_sak = 1'b1;
          if (~ack) begin
            if (n_wl | n_bulk) begin
              d_go = ST_STBY;
              d_wc = n_bulk ? WC_LONG : WC_NONE;
            end else begin
              d_sak = 1'b0;
            end
          end else if (n_wl | n_bulk) begin
            d_sak = 1'b0;
          end else if (n_rd | n_wr) begin
            d_go = ST_RXB;
            d_phase = PH_ARG;
            d_nargs = `MSWL_ARG_BYTES;
          end else if (n_ws) begin
            d_go = ST_RXB;
            d_phase = PH_DAT;
          end else if (TX_VALID) begin
            d_go = ST_TX;
            d_phase = PH_TXD;
          end else begin
            d_sak = 1'b0;
          end
        end
      end
      PH_ARG: begin
        if (ack) begin
          d_push = 1'b1;
          d_sak = 1'b1;
          d_nargs = nargs_q - 2'h1;
          if (nargs_q != 2'h1) begin
            d_go = ST_RXB;
          end else if (c_rd) begin
            d_go = TX_VALID ? ST_TX : ST_IDLE;
            d_sak = TX_VALID;
            d_phase = PH_TXD;
          end else begin
            d_go = ST_RXB;
            d_phase = PH_DAT;
          end
        end
      end
      PH_DAT: begin
        d_push = 1'b1;
        d_sak = 1'b1;
        if (~ack) begin
          d_go = ST_STBY;
          d_wc = (c_wr | c_ws) ? WC_SHORT : WC_NONE;
        end else if (c_ws) begin
          d_sak = 1'b0;
        end else begin
          d_go = ST_RXB;
        end
      end
      PH_TXD: begin
        if (~ack) begin
          d_sak = 1'b1;
          d_go = ST_STBY;
        end else if (TX_VALID) begin
          d_sak = 1'b1;
          d_go = ST_TX;
        end
      end
      default: begin
        d_go = ST_IDLE;
      end
    endcase
    // a full receive buffer cannot take the byte, so refuse it
    if (d_push & ~buf_rdy) begin
      d_sak = 1'b0;
      d_go = ST_IDLE;
    end
    if (d_go == ST_IDLE) begin
      d_push = 1'b0;
      d_wc = WC_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main sequencer
  always @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      tcnt_q <= 16'h0;
      period_q <= 16'h0;
      sub_q <= 3'h0;
      ecnt_q <= 3'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      ph_q <= 1'b0;
      phase_q <= PH_HDR;
      cmd_q <= 8'h0;
      nargs_q <= 2'h0;
      sak_q <= 1'b0;
      go_q <= ST_IDLE;
      oe_q <= 1'b0;
      out_q <= 1'b1;
      txb_q <= 8'h0;
      push_q <= 1'b0;
      pushd_q <= 8'h0;
    end else begin
      push_q <= ack_take & d_push;
      if (ack_take) begin
        pushd_q <= sh_q;
      end
      if (tcnt_q != 16'hffff) begin
        tcnt_q <= tcnt_q + 16'h1;
      end
      if (stby_hit) begin
        state_q <= ST_STBY;
        oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_STBY: begin
            if (fall) begin
              state_q <= ST_HLOW;
              tcnt_q <= 16'h0;
            end
          end
          ST_HLOW: begin
            if (rise) begin
              tcnt_q <= 16'h0;
              ecnt_q <= 3'h0;
              period_q <= 16'h0;
              sub_q <= 3'h0;
              state_q <= (tcnt_q >= HDR_LOW_CYC - 16'h1) ? ST_HMEAS : ST_IDLE;
            end
          end
          ST_HMEAS: begin
            // 0x55 has only mid edges: seven periods between first and eighth
            // first edge's own cycle counts too, else an exact minimum period reads short
            if ((ecnt_q != 3'h0) | edge_any) begin
              if (sub_q == 3'h6) begin
                sub_q <= 3'h0;
                period_q <= period_q + 16'h1;
              end else begin
                sub_q <= sub_q + 3'h1;
              end
            end
            if (period_q > TE_MAX_CYC) begin
              state_q <= ST_IDLE;
            end else if (edge_any) begin
              ecnt_q <= ecnt_q + 3'h1;
              tcnt_q <= 16'h0;
              if (ecnt_q == 3'h7) begin
                state_q <= (period_q < TE_MIN_CYC) ? ST_IDLE : ST_RXB;
                bit_q <= 4'd8;
                phase_q <= PH_HDR;
              end
            end
          end
          ST_RXB: begin
            if (missed) begin
              state_q <= ST_IDLE;
            end else if (in_win) begin
              tcnt_q <= 16'h0;
              if (bit_q != 4'd8) begin
                sh_q <= {sh_q[6:0], rise};
                bit_q <= bit_q + 4'h1;
              end else begin
                sak_q <= d_sak;
                go_q <= d_go;
                phase_q <= d_phase;
                nargs_q <= d_nargs;
                ph_q <= 1'b0;
                state_q <= ST_SACK;
                if (phase_q == PH_CMD) begin
                  cmd_q <= sh_q;
                end
              end
            end
          end
          ST_SACK: begin
            if (~ph_q) begin
              if (tcnt_q == half) begin
                oe_q <= sak_q;
                out_q <= 1'b0;
              end else if (tcnt_q == period_q) begin
                out_q <= 1'b1;
                tcnt_q <= 16'h0;
                ph_q <= 1'b1;
              end
            end else if (tcnt_q == half) begin
              bit_q <= 4'h0;
              state_q <= go_q;
              if (go_q == ST_TX) begin
                txb_q <= TX_DATA;
                out_q <= ~TX_DATA[7];
                oe_q <= 1'b1;
              end else begin
                oe_q <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (~ph_q) begin
              if (tcnt_q == half) begin
                if (bit_q == 4'd8) begin
                  oe_q <= 1'b0;
                  state_q <= ST_RXB;
                end else begin
                  out_q <= ~txb_q[7];
                  ph_q <= 1'b1;
                end
              end
            end else if (tcnt_q == period_q) begin
              out_q <= txb_q[7];
              txb_q <= {txb_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              tcnt_q <= 16'h0;
              ph_q <= 1'b0;
            end
          end
          ST_IDLE: begin
            oe_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // self-timed write cycle; keeps running through standby
  always @(posedge CLK) begin
    if (RESET) begin
      wc_q <= 21'h0;
      wcs_q <= 1'b0;
      wcb_q <= 1'b0;
    end else begin
      wcs_q <= 1'b0;
      if (ack_take & (d_wc != WC_NONE)) begin
        wc_q <= (d_wc == WC_LONG) ? WC_LONG_CYC : WC_SHORT_CYC;
        wcs_q <= 1'b1;
        wcb_q <= (d_wc == WC_LONG);
      end else if (busy) begin
        wc_q <= wc_q - 21'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // received bytes toward the user
  mswl_skid_buf #(
    .W(8),
    .DEPTH(2),
    .AW(1)
  ) u_rx_buf (
    .clk(CLK),
    .rst(RESET),
    .in_valid(push_q),
    .in_ready(buf_rdy),
    .in_data(pushd_q),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_DATA)
  );

  assign TX_READY = (state_q == ST_SACK) & ph_q & (tcnt_q == half) & (go_q == ST_TX);
  assign SIO_OUT = out_q;
  assign SIO_OE_N = ~oe_q;
  assign WC_START = wcs_q;
  assign WC_BULK = wcb_q;
  assign WRITE_BUSY = busy;
endmodule

// ---- mswl_link_assertions.sv ----
`timescale 1ns/1ps
module mswl_link_chk #(
  parameter [20:0] WC_SHORT_CYC = 21'h098968,
  parameter [20:0] WC_LONG_CYC = 21'h1312d0
) (
  input wire CLK,
  input wire RESET,
  input wire SIO_OUT,
  input wire SIO_OE_N,
  input wire [7:0] RX_DATA,
  input wire RX_VALID,
  input wire RX_READY,
  input wire TX_VALID,
  input wire TX_READY,
  input wire WC_START,
  input wire WC_BULK,
  input wire WRITE_BUSY
);
  // busy run length, counted here since it far exceeds a repetition
  reg [20:0] busy_cnt_q;
  wire [20:0] busy_cnt_d = WRITE_BUSY ? busy_cnt_q + 21'h1 : 21'h0;
  always @(posedge CLK) begin
    if (RESET) busy_cnt_q <= 21'h0;
    else busy_cnt_q <= busy_cnt_d;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_reset_quiet;
    $fell(RESET) |-> SIO_OE_N && !RX_VALID && !TX_READY && !WC_START && !WRITE_BUSY;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_wc_busy;
    WC_START |-> $rose(WRITE_BUSY);
  endproperty
  a_wc_busy: assert property (p_wc_busy) else $error("start without busy rise");
  property p_busy_cause;
    $rose(WRITE_BUSY) |-> WC_START;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without start");
  property p_wc_pulse;
    WC_START |=> !WC_START;
  endproperty
  a_wc_pulse: assert property (p_wc_pulse) else $error("start pulse too long");
  property p_busy_len;
    $fell(WRITE_BUSY) |-> busy_cnt_q == (WC_BULK ? WC_LONG_CYC : WC_SHORT_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_bulk_hold;
    WRITE_BUSY && !WC_START |-> $stable(WC_BULK);
  endproperty
  a_bulk_hold: assert property (p_bulk_hold) else $error("bulk flag moved");
  property p_tx_pulse;
    TX_READY |-> TX_VALID ##1 !TX_READY;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx take pulse wrong");
  property p_rx_hold;
    RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte lost in stall");
  property p_oe_width;
    $fell(SIO_OE_N) |=> !SIO_OE_N [*8];
  endproperty
  a_oe_width: assert property (p_oe_width) else $error("drive too short");
  property p_out_width;
    !SIO_OE_N && $changed(SIO_OUT) |=> $stable(SIO_OUT) [*8];
  endproperty
  a_out_width: assert property (p_out_width) else $error("output edges too close");
  property p_push_quiet;
    $rose(RX_VALID) |-> SIO_OE_N;
  endproperty
  a_push_quiet: assert property (p_push_quiet) else $error("push while driving");
  c_start: cover property (WC_START);
  c_tx: cover property (TX_READY);
  c_drive: cover property ($fell(SIO_OE_N));
  c_stall: cover property (RX_VALID && !RX_READY);
endmodule
bind mswl_link mswl_link_chk #(
  .WC_SHORT_CYC(WC_SHORT_CYC),
  .WC_LONG_CYC(WC_LONG_CYC)
) mswl_link_chk_i (
  .CLK(CLK), .RESET(RESET), .SIO_OUT(SIO_OUT), .SIO_OE_N(SIO_OE_N),
  .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
  .TX_VALID(TX_VALID), .TX_READY(TX_READY), .WC_START(WC_START),
  .WC_BULK(WC_BULK), .WRITE_BUSY(WRITE_BUSY)
);

// ---- mswl_master_model.sv ----
`timescale 1ns/1ps
module mswl_master_model #(
  parameter HALF = 625,
  parameter STBY = 5100
) (
  input wire clk,
  input wire line,
  output reg drv,
  output reg en
);
  // low from power-up so the first standby is a real rise
  initial begin
    drv = 1'b0;
    en = 1'b1;
  end
  task hold(input v, input integer n);
    begin
      drv <= v;
      en <= 1'b1;
      repeat (n) @(posedge clk);
    end
  endtask
  // level after the mid edge is the bit; 10 us period, no jitter
  task send_bit(input b);
    begin
      hold(!b, HALF);
      hold(b, HALF);
    end
  endtask
  // only called while the master holds the line low
  task standby;
    hold(1'b1, STBY);
  endtask
  task get_bit(output b, output m);
    reg a;
    begin
      en <= 1'b0;
      repeat (HALF / 2) @(posedge clk);
      a = line;
      repeat (HALF) @(posedge clk);
      b = line;
      m = a ^ b;
      repeat (HALF - HALF / 2) @(posedge clk);
    end
  endtask
  // slave bit is an ack only with a rising mid edge
  task ack_rt(input master_ack, output slave_ack);
    reg b;
    reg m;
    begin
      send_bit(master_ack);
      get_bit(b, m);
      slave_ack = b & m;
    end
  endtask
  task tx_byte(input [7:0] d, input master_ack, output slave_ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) send_bit(d[i]);
      ack_rt(master_ack, slave_ack);
    end
  endtask
  task rx_byte(output [7:0] d, input master_ack, output slave_ack);
    integer i;
    reg m;
    begin
      for (i = 7; i >= 0; i = i - 1) get_bit(d[i], m);
      ack_rt(master_ack, slave_ack);
    end
  endtask
  // 10 us low, sync byte, always a master ack
  task header(output slave_ack);
    begin
      hold(1'b0, 2 * HALF);
      tx_byte(8'h55, 1'b1, slave_ack);
    end
  endtask
endmodule

// ---- mswl_link_tb.sv ----
`timescale 1ns/1ps
module mswl_link_tb;
  localparam HALF = 625;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg rx_ready = 1'b1;
  reg [7:0] tx_data = 8'h00;
  reg tx_valid = 1'b0;
  reg bulk_q = 1'b0;
  reg slave_ack;
  reg [7:0] rd;
  reg [7:0] exp_tx;
  reg [31:0] rnd;
  reg [7:0] exp_q[$];
  integer seed = 78;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer tx_n = 0;
  integer wc_n = 0;
  integer busy_n = 0;
  wire m_drv;
  wire m_en;
  wire sio_out;
  wire sio_oe_n;
  wire rx_valid;
  wire tx_ready;
  wire wc_start;
  wire wc_bulk;
  wire busy;
  wire [7:0] rx_data;
  // released line floats up to the pull-up level
  wire line = !sio_oe_n ? sio_out : (m_en ? m_drv : 1'b1);
  always #4 clk = ~clk;
  mswl_link #(
    .STBY_CYC(17'h01388),
    .WC_SHORT_CYC(21'h00012c), .WC_LONG_CYC(21'h000258)
  ) mswl_link_i (
    .CLK(clk), .RESET(rst), .SIO_IN(line), .SIO_OUT(sio_out), .SIO_OE_N(sio_oe_n),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .WC_START(wc_start), .WC_BULK(wc_bulk),
    .WRITE_BUSY(busy)
  );
  // model defaults give the same half bit as HALF here and a standby above STBY_CYC
  mswl_master_model mswl_master_model_i (
    .clk(clk), .line(line), .drv(m_drv), .en(m_en)
  );
  task check(input string what, input [15:0] e, input [15:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %s expected %h seen %h", what, e, got);
      end
    end
  endtask
  task ack(input string what, input e);
    check(what, {15'h0, e}, {15'h0, slave_ack});
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // pops against the oldest note; random stalls on the receive side
  always @(posedge clk) begin
    rx_ready <= ^$random(seed);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) check("rx surplus", 16'h0, 16'h1);
      else check("rx byte", {8'h0, exp_q.pop_front()}, {8'h0, rx_data});
    end
    if (tx_ready === 1'b1) begin
      tx_valid <= 1'b0;
      tx_n <= tx_n + 1;
    end
    if (wc_start === 1'b1) wc_n <= wc_n + 1;
    if (busy === 1'b1) busy_n <= busy_n + 1;
    if (busy === 1'b1 && wc_start !== 1'b1) bulk_q <= wc_bulk;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    mswl_master_model_i.standby;
    mswl_master_model_i.header(slave_ack);
    ack("header ack", 1'b0);
    mswl_master_model_i.tx_byte(8'ha0, 1'b1, slave_ack);
    ack("addr ack", 1'b1);
    rnd = $random(seed);
    exp_tx = rnd[7:0];
    tx_data <= exp_tx;
    tx_valid <= 1'b1;
    exp_q.push_back(8'h05);
    mswl_master_model_i.tx_byte(8'h05, 1'b1, slave_ack);
    ack("cmd ack", 1'b1);
    mswl_master_model_i.rx_byte(rd, 1'b0, slave_ack);
    check("read byte", {8'h0, exp_tx}, {8'h0, rd});
    ack("end ack", 1'b1);
    check("tx taken", 16'h1, tx_n[15:0]);
    $display("test status read done");
    mswl_master_model_i.hold(1'b1, 2 * HALF);
    mswl_master_model_i.header(slave_ack);
    mswl_master_model_i.tx_byte(8'ha0, 1'b1, slave_ack);
    ack("addr again", 1'b1);
    exp_q.push_back(8'h67);
    mswl_master_model_i.tx_byte(8'h67, 1'b0, slave_ack);
    ack("set ack", 1'b1);
    check("write starts", 16'h1, wc_n[15:0]);
    check("bulk flag", 16'h1, {15'h0, bulk_q});
    check("busy cycles", 16'h0258, busy_n[15:0]);
    $display("test set all done");
    mswl_master_model_i.hold(1'b1, 2 * HALF);
    mswl_master_model_i.header(slave_ack);
    mswl_master_model_i.tx_byte(8'ha1, 1'b1, slave_ack);
    ack("other addr", 1'b0);
    mswl_master_model_i.tx_byte(8'h05, 1'b1, slave_ack);
    ack("idle ack", 1'b0);
    check("rx left", 16'h0, 16'(exp_q.size()));
    $display("test wrong address done");
    test_done;
  end
  // run needs about 1.1 ms
  initial begin
    #1500000;
    error_cnt = error_cnt + 1;
    test_done;
  end
endmodule
